/* File: core/vpic_top.sv */
/*
 Vectored priority interrupt controller: flag, enable and priority banks,
 external pin edge detection, arbitration and the request to the core.
 Assumes peripheral sources are on clk; external pins are asynchronous.
*/
`timescale 1ns/1ps
module vpic_top
   import vpic_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic [NSRC-1:0]        src_evt,
   input  wire logic [NEXT-1:0]        ext_pin,
   input  wire logic [NEXT-1:0]        ext_rise_sel,
   input  wire logic                   multi_vec_en,
   input  wire logic [NLEVELS*SRS_W-1:0] srs_map,
   input  wire logic                   cfg_we,
   input  wire logic [2:0]             cfg_sel,
   input  wire logic [IDX_W-1:0]       cfg_idx,
   input  wire logic [WORD_W-1:0]      cfg_wdata,
   output logic      [NSRC-1:0]        irq_flag_bank,
   output logic      [NSRC-1:0]        irq_enable_bank,
   output logic      [NSRC*PRI_W-1:0]  irq_priority_bank,
   output logic      [NSRC*SUB_W-1:0]  irq_subpri_bank,
   output logic                        irq_req_r,
   output logic      [IDX_W-1:0]       irq_vec_r,
   output logic      [IDX_W-1:0]       irq_src_r,
   output logic      [PRI_W-1:0]       irq_pri_r,
   output logic      [SUB_W-1:0]       irq_sub_r,
   output logic      [SRS_W-1:0]       irq_srs_r,
   output logic      [VADDR_W-1:0]     irq_offset_r
);

   vpic_sel_t             sel;
   logic [NSRC-1:0]       flag_r;
   logic [NSRC-1:0]       flag_nxt;
   logic [NSRC-1:0]       en_r;
   logic [NSRC-1:0]       en_nxt;
   logic [NSRC*PRI_W-1:0] pri_r;
   logic [NSRC*PRI_W-1:0] pri_nxt;
   logic [NSRC*SUB_W-1:0] sub_r;
   logic [NSRC*SUB_W-1:0] sub_nxt;
   logic [NSRC-1:0]       src_prev_r;
   logic [NSRC-1:0]       ext_hit;
   logic [NSRC-1:0]       pend;

   logic [NEXT-1:0]       ext_meta_r;
   logic [NEXT-1:0]       ext_sync_r;
   logic [NEXT-1:0]       ext_prev_r;
   logic [NEXT-1:0]       ext_edge;

   logic                  win_vld;
   logic [IDX_W-1:0]      win_idx;
   logic [PRI_W-1:0]      win_pri;
   logic [SUB_W-1:0]      win_sub;
   logic [IDX_W-1:0]      vec_sel;
   logic [OFF_W-1:0]      off_rd;
   logic                  off_we;

   logic                  req_nxt;
   logic [IDX_W-1:0]      vec_nxt;
   logic [SRS_W-1:0]      srs_nxt;

   assign sel = vpic_sel_t'(cfg_sel);

   // Banks are visible to software as plain status outputs
   assign irq_flag_bank     = flag_r;
   assign irq_enable_bank   = en_r;
   assign irq_priority_bank = pri_r;
   assign irq_subpri_bank   = sub_r;

   // RULE_03: pin synchroniser
   // Pins are asynchronous; only the second and third stages feed the edge detector.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_meta_r <= '0;
         ext_sync_r <= '0;
         ext_prev_r <= '0;
      end else begin
         ext_meta_r <= ext_pin;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
      end
   end

   // RULE_03: polarity-selected edge
   // Polarity change while a pin is steady raises nothing: only transitions count.
   always_comb begin
      for (int p = 0; p < NEXT; p++) begin
         ext_edge[p] = ext_rise_sel[p] ? (ext_sync_r[p] & ~ext_prev_r[p])
                                       : (~ext_sync_r[p] & ext_prev_r[p]);
      end
   end

   // Route each pin edge onto its own source number
   always_comb begin
      ext_hit = '0;
      for (int p = 0; p < NEXT; p++) begin
         ext_hit[EXT_IRQ[p*IDX_W +: IDX_W]] = ext_hit[EXT_IRQ[p*IDX_W +: IDX_W]] | ext_edge[p];
      end
   end

   // Previous level of each peripheral line, for non-persistent edge capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         src_prev_r <= '0;
      end else begin
         src_prev_r <= src_evt;
      end
   end

   // RULE_01: one slot per source
   // RULE_09: per-source flag and enable
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         localparam int WIDX = gi / WORD_W;
         localparam int WBIT = gi % WORD_W;
         localparam int PIDX = gi / SRC_PER_PRI_WORD;
         localparam int PBYT = gi % SRC_PER_PRI_WORD;
         logic hw_evt;
         logic sw_set;
         logic sw_clr;
         logic wr_word;
         logic wr_pri;

         assign wr_word = cfg_we && (cfg_idx == IDX_W'(WIDX));
         assign wr_pri  = cfg_we && (sel == VPIC_SEL_PRIORITY) && (cfg_idx == IDX_W'(PIDX));

         // RULE_12: persistent versus edge
         // RULE_14: level holds flag
         // Persistent sources follow the condition level; others fire on its rise.
         assign hw_evt = (NON_PERSIST[gi] ? (src_evt[gi] & ~src_prev_r[gi]) : src_evt[gi])
                         | ext_hit[gi];
         // RULE_07: software set
         assign sw_set = wr_word && (sel == VPIC_SEL_FLAG_SET) && cfg_wdata[WBIT];
         assign sw_clr = wr_word && (sel == VPIC_SEL_FLAG_CLR) && cfg_wdata[WBIT];

         // Set wins over a clear landing in the same cycle
         always_comb begin
            flag_nxt[gi] = (flag_r[gi] & ~sw_clr) | sw_set | hw_evt;
            en_nxt[gi]   = (wr_word && (sel == VPIC_SEL_ENABLE)) ? cfg_wdata[WBIT] : en_r[gi];
         end

         // RULE_10: byte-lane priority fields
         always_comb begin
            pri_nxt[gi*PRI_W +: PRI_W] = wr_pri ? cfg_wdata[PBYT*BYTE_W+PRI_LSB +: PRI_W]
                                                : pri_r[gi*PRI_W +: PRI_W];
            sub_nxt[gi*SUB_W +: SUB_W] = wr_pri ? cfg_wdata[PBYT*BYTE_W+SUB_LSB +: SUB_W]
                                                : sub_r[gi*SUB_W +: SUB_W];
         end

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               flag_r[gi]               <= 1'b0;
               en_r[gi]                 <= 1'b0;
               pri_r[gi*PRI_W +: PRI_W] <= '0;
               sub_r[gi*SUB_W +: SUB_W] <= '0;
            end else begin
               flag_r[gi]               <= flag_nxt[gi];
               en_r[gi]                 <= en_nxt[gi];
               pri_r[gi*PRI_W +: PRI_W] <= pri_nxt[gi*PRI_W +: PRI_W];
               sub_r[gi*SUB_W +: SUB_W] <= sub_nxt[gi*SUB_W +: SUB_W];
            end
         end
      end
   endgenerate

   // RULE_08: only enabled flags compete
   assign pend = flag_r & en_r;

   // RULE_13: arbitration stage
   vpic_arbiter u_arb (
      .clk       (clk),
      .rst_b     (rst_b),
      .pend      (pend),
      .pri_flat  (pri_r),
      .sub_flat  (sub_r),
      .win_vld_r (win_vld),
      .win_idx_r (win_idx),
      .win_pri_r (win_pri),
      .win_sub_r (win_sub)
   );

   // RULE_02: vector selection by mode
   // Single-vector mode funnels every source to one shared entry.
   assign vec_sel = multi_vec_en ? win_idx : SINGLE_VEC;

   // RULE_11: offset write, bit 0 dropped
   assign off_we = cfg_we && (sel == VPIC_SEL_OFFSET);

   vpic_offset_mem u_off (
      .clk       (clk),
      .rst_b     (rst_b),
      .wr_en     (off_we),
      .wr_addr   (cfg_idx),
      .wr_data   (cfg_wdata[OFF_LSB +: OFF_W]),
      .rd_addr   (vec_sel),
      .rd_data_r (off_rd)
   );

   // RULE_06: shadow set by winning level
   always_comb begin
      req_nxt = win_vld;
      vec_nxt = vec_sel;
      srs_nxt = '0;
      if (win_pri != PRI_OFF) begin
         srs_nxt = srs_map[(int'(win_pri)-1)*SRS_W +: SRS_W];
      end
   end

   // Presentation stage, aligned with the registered offset read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_req_r <= 1'b0;
         irq_vec_r <= '0;
         irq_src_r <= '0;
         irq_pri_r <= '0;
         irq_sub_r <= '0;
         irq_srs_r <= '0;
      end else begin
         irq_req_r <= req_nxt;
         irq_vec_r <= vec_nxt;
         irq_src_r <= win_idx;
         irq_pri_r <= win_pri;
         irq_sub_r <= win_sub;
         irq_srs_r <= srs_nxt;
      end
   end

   // RULE_11: halfword-aligned offset
   assign irq_offset_r = {off_rd, 1'b0};

endmodule

/* File: core/vpic_pkg.sv */
/*
 Constants, field layouts and types of the vectored priority interrupt
 controller. Assumes a single 250 MHz clock domain around the block.
*/
// Contract
// RULE_01: Up to 190 sources, each with its own vector and programmable offset.
// RULE_02: Single-vector mode shares one entry; multi-vector mode uses per-source vectors.
// RULE_03: Five external pins, each with its own rising or falling edge select.
// RULE_04: Seven usable priority levels per vector decide which request reaches the core.
// RULE_05: Four subpriority levels order requests sharing one priority.
// RULE_06: Any of seven shadow sets maps to any priority and is signalled.
// RULE_07: Software setting a flag raises the interrupt like a hardware event.
// RULE_08: Separate unit: collect events, prioritize, then present one request to core.
// RULE_09: One flag and enable bit per source, 32 per bank word.
// RULE_10: Priority words hold four sources; priority bits 4:2, subpriority 1:0.
// RULE_11: Per-vector offset held in bits 17:1; bit 0 not stored.
// RULE_12: Each source is persistent or not; clock and flash sources are not.
// RULE_13: Highest priority wins, then higher subpriority, then lower number; zero never.
// RULE_14: Persistent flag stays set while its condition holds, despite software clear.
package vpic_pkg;

   localparam int NSRC      = 190;
   localparam int IDX_W     = 8;
   localparam int WORD_W    = 32;
   localparam int NWORDS    = 6;
   localparam int BYTE_W    = 8;
   localparam int SRC_PER_PRI_WORD = 4;
   localparam int PRI_W     = 3;
   localparam int SUB_W     = 2;
   localparam int PRI_LSB   = 2;
   localparam int SUB_LSB   = 0;
   localparam int OFF_W     = 17;
   localparam int OFF_LSB   = 1;
   localparam int VADDR_W   = 18;
   localparam int NEXT      = 5;
   localparam int NLEVELS   = 7;
   localparam int SRS_W     = 3;

   // Vector used for every source in single-vector mode
   localparam logic [IDX_W-1:0] SINGLE_VEC = 8'h00;
   localparam logic [PRI_W-1:0] PRI_OFF    = 3'h0;

   // Sources fed by the external pins, highest pin first
   localparam logic [NEXT*IDX_W-1:0] EXT_IRQ = {8'h17, 8'h12, 8'h0d, 8'h08, 8'h03};

   // Non-persistent sources: real-time clock (166) and flash control (167)
   localparam logic [NSRC-1:0] NON_PERSIST = 190'h0 | (190'h3 << 166);

   // Configuration write selector
   typedef enum logic [2:0] {
      VPIC_SEL_FLAG_SET,
      VPIC_SEL_FLAG_CLR,
      VPIC_SEL_ENABLE,
      VPIC_SEL_PRIORITY,
      VPIC_SEL_OFFSET
   } vpic_sel_t;

endpackage

/* File: core/vpic_offset_mem.sv */
/*
 Per-vector handler offset store: one write port, one read port with a
 registered read. Assumes the owner presents a valid address every cycle.
*/
`timescale 1ns/1ps
module vpic_offset_mem
   import vpic_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_addr,
   input  wire logic [OFF_W-1:0] wr_data,
   input  wire logic [IDX_W-1:0] rd_addr,
   output logic      [OFF_W-1:0] rd_data_r
);

   logic [OFF_W-1:0] mem [NSRC];

   // Storage is left unreset so it maps onto a RAM macro
   always_ff @(posedge clk) begin
      if (wr_en && (wr_addr < IDX_W'(NSRC))) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read; out-of-range addresses read zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_r <= '0;
      end else if (rd_addr < IDX_W'(NSRC)) begin
         rd_data_r <= mem[rd_addr];
      end else begin
         rd_data_r <= '0;
      end
   end

endmodule

/* File: core/vpic_arbiter.sv */
/*
 Picks the winning pending source by priority, subpriority, then number.
 Assumes pending bits already combine flag and enable; result is registered.
*/
`timescale 1ns/1ps
module vpic_arbiter
   import vpic_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic [NSRC-1:0]       pend,
   input  wire logic [NSRC*PRI_W-1:0] pri_flat,
   input  wire logic [NSRC*SUB_W-1:0] sub_flat,
   output logic                       win_vld_r,
   output logic      [IDX_W-1:0]      win_idx_r,
   output logic      [PRI_W-1:0]      win_pri_r,
   output logic      [SUB_W-1:0]      win_sub_r
);

   logic                         win_vld_nxt;
   logic [IDX_W-1:0]             win_idx_nxt;
   logic [PRI_W+SUB_W-1:0]       best_key;

   // RULE_13: ordered key scan
   // Ascending scan with strict compare keeps the lower number on ties;
   // one long comparison chain, traded for area over a balanced tree.
   always_comb begin
      win_vld_nxt = 1'b0;
      win_idx_nxt = '0;
      best_key    = '0;
      for (int i = 0; i < NSRC; i++) begin
         // RULE_04: priority zero excluded
         if (pend[i] && (pri_flat[i*PRI_W +: PRI_W] != PRI_OFF) &&
             ({pri_flat[i*PRI_W +: PRI_W], sub_flat[i*SUB_W +: SUB_W]} > best_key ||
              !win_vld_nxt)) begin
            win_vld_nxt = 1'b1;
            win_idx_nxt = IDX_W'(i);
            // RULE_05: subpriority in low key bits
            best_key    = {pri_flat[i*PRI_W +: PRI_W], sub_flat[i*SUB_W +: SUB_W]};
         end
      end
   end

   // Winner register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         win_vld_r <= 1'b0;
         win_idx_r <= '0;
         win_pri_r <= '0;
         win_sub_r <= '0;
      end else begin
         win_vld_r <= win_vld_nxt;
         win_idx_r <= win_idx_nxt;
         win_pri_r <= best_key[PRI_W+SUB_W-1:SUB_W];
         win_sub_r <= best_key[SUB_W-1:0];
      end
   end

endmodule

/* File: verif/vpic_monitor.sv */
/*
 Checker for the interrupt controller top: request fields, flag updates.
 Assumes it sees only top ports, bound by the bind statement at the foot.
*/
`timescale 1ns/1ps
module vpic_monitor
   import vpic_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     rst_b,
   input wire logic [NSRC-1:0]          src_evt,
   input wire logic                     multi_vec_en,
   input wire logic [NLEVELS*SRS_W-1:0] srs_map,
   input wire logic                     cfg_we,
   input wire logic [2:0]               cfg_sel,
   input wire logic [IDX_W-1:0]         cfg_idx,
   input wire logic [WORD_W-1:0]        cfg_wdata,
   input wire logic [NSRC-1:0]          irq_flag_bank,
   input wire logic [NSRC-1:0]          irq_enable_bank,
   input wire logic                     irq_req_r,
   input wire logic [IDX_W-1:0]         irq_vec_r,
   input wire logic [IDX_W-1:0]         irq_src_r,
   input wire logic [PRI_W-1:0]         irq_pri_r,
   input wire logic [SRS_W-1:0]         irq_srs_r
);
   logic [NSRC-1:0] pend_d1_r;
   logic [NSRC-1:0] pend_d2_r;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Pending set as the arbiter saw it; the request lags it by two edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_d1_r <= '0;
         pend_d2_r <= '0;
      end else begin
         pend_d1_r <= irq_flag_bank & irq_enable_bank;
         pend_d2_r <= pend_d1_r;
      end
   end

   sequence s_flag_write;
      cfg_we && cfg_sel == 3'h0 && cfg_idx < 8'h6;
   endsequence

   a_flag_sw_set: assert property (s_flag_write |=>
      // Bits above the last source in the top word have no flag behind them
      ((32'({2'h0, irq_flag_bank} >> (32 * $past(cfg_idx)))) & $past(cfg_wdata))
      == ((32'({2'h0, {NSRC{1'b1}}} >> (32 * $past(cfg_idx)))) & $past(cfg_wdata)))
      else $error("software set left a flag clear");
   a_persist_level: assert property (1'b1 |=>
      (irq_flag_bank & $past(src_evt & ~NON_PERSIST)) == $past(src_evt & ~NON_PERSIST))
      else $error("persistent flag not held by its level");
   a_pri_nonzero: assert property (irq_req_r |-> irq_pri_r != PRI_OFF)
      else $error("request with priority zero");
   a_req_pending: assert property (irq_req_r |-> pend_d2_r[irq_src_r])
      else $error("request for a source not pending");
   a_idle_no_req: assert property (pend_d2_r == '0 |-> !irq_req_r)
      else $error("request with nothing pending");
   a_srs_select: assert property (irq_req_r |->
      irq_srs_r == srs_map[3 * (int'(irq_pri_r) - 1) +: 3]) else $error("wrong shadow set");
   a_single_vec: assert property (irq_req_r && !$past(multi_vec_en, 1) |->
      irq_vec_r == SINGLE_VEC) else $error("single mode vector not shared");
   a_multi_vec: assert property (irq_req_r && $past(multi_vec_en, 1) |->
      irq_vec_r == irq_src_r) else $error("multi mode vector not the source");
endmodule

bind vpic_top vpic_monitor vpic_monitor_inst (.clk(clk), .rst_b(rst_b), .src_evt(src_evt),
   .multi_vec_en(multi_vec_en), .srs_map(srs_map), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
   .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata), .irq_flag_bank(irq_flag_bank),
   .irq_enable_bank(irq_enable_bank), .irq_req_r(irq_req_r), .irq_vec_r(irq_vec_r),
   .irq_src_r(irq_src_r), .irq_pri_r(irq_pri_r), .irq_srs_r(irq_srs_r));

/* File: verif/vpic_core_model.sv */
/*
 Core model: takes the presented request and keeps the source it serves.
 Assumes the request level and source come from registers on clk.
*/
`timescale 1ns/1ps
module vpic_core_model
   import vpic_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             irq_req_r,
   input  wire logic [IDX_W-1:0] irq_src_r,
   output logic      [IDX_W-1:0] taken_src_r
);
   // core sees only the winner
   // No ack exists, so the core takes the source of each presented request and holds it while no request is up
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         taken_src_r <= 8'h00;
      end else if (irq_req_r) begin
         taken_src_r <= irq_src_r;
      end
   end
endmodule

/* File: verif/tb.sv */
/*
 Self-checking bench for the interrupt controller with a core model.
 Assumes the checker is bound to the top and a 250 MHz clock.
*/
`timescale 1ns/1ps
module tb import vpic_pkg::*;;
   logic                     clk, rst_b, multi_vec_en, cfg_we, irq_req_r;
   logic [NSRC-1:0]          src_evt, irq_flag_bank, irq_enable_bank;
   logic [NEXT-1:0]          ext_pin, ext_rise_sel;
   logic [NLEVELS*SRS_W-1:0] srs_map;
   logic [2:0]               cfg_sel;
   logic [IDX_W-1:0]         cfg_idx, irq_vec_r, irq_src_r, taken_src;
   logic [WORD_W-1:0]        cfg_wdata;
   logic [NSRC*PRI_W-1:0]    pri_bank;
   logic [NSRC*SUB_W-1:0]    sub_bank;
   logic [PRI_W-1:0]         irq_pri_r;
   logic [SUB_W-1:0]         irq_sub_r;
   logic [SRS_W-1:0]         irq_srs_r;
   logic [VADDR_W-1:0]       irq_offset_r;
   int                       error_cnt, tests_run, cyc;

   vpic_top vpic_top_inst (.clk(clk), .rst_b(rst_b), .src_evt(src_evt), .ext_pin(ext_pin),
      .ext_rise_sel(ext_rise_sel), .multi_vec_en(multi_vec_en), .srs_map(srs_map),
      .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
      .irq_flag_bank(irq_flag_bank), .irq_enable_bank(irq_enable_bank),
      .irq_priority_bank(pri_bank), .irq_subpri_bank(sub_bank), .irq_req_r(irq_req_r),
      .irq_vec_r(irq_vec_r), .irq_src_r(irq_src_r), .irq_pri_r(irq_pri_r),
      .irq_sub_r(irq_sub_r), .irq_srs_r(irq_srs_r), .irq_offset_r(irq_offset_r));
   vpic_core_model vpic_core_model_inst (.clk(clk), .rst_b(rst_b), .irq_req_r(irq_req_r),
      .irq_src_r(irq_src_r), .taken_src_r(taken_src));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard: the full run needs under a hundred cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One write pulse; the next call leaves a gap cycle before raising it again
   task automatic cfg(input logic [2:0] s, input logic [7:0] i, input logic [31:0] d);
      @(posedge clk);
      cfg_we <= 1'b1;
      cfg_sel <= s;
      cfg_idx <= i;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_we <= 1'b0;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Shadow set is mapped as 8 minus the priority
   task automatic expect_req(input logic [7:0] s, input logic [7:0] v, input logic [2:0] p,
                             input logic [1:0] sb, input logic [17:0] off);
      check(32'({irq_req_r, irq_src_r, taken_src}), {15'h0, 1'b1, s, s});
      check(32'({irq_vec_r, irq_pri_r, irq_sub_r}), 32'({v, p, sb}));
      check(32'(irq_srs_r), 32'(4'h8 - p));
      check(32'(irq_offset_r), 32'(off));
   endtask

   task automatic t_arbitrate;
      cfg(3'h4, 8'h00, 32'h0000_1234);
      cfg(3'h4, 8'ha0, 32'h0002_abcd);
      cfg(3'h4, 8'ha1, 32'h0000_0101);
      cfg(3'h3, 8'h28, 32'h000e_0e0d);
      cfg(3'h2, 8'h05, 32'h0040_004f);
      cfg(3'h0, 8'h05, 32'h0000_0008);
      wait_cyc(3);
      check(32'({pri_bank[480+:3], sub_bank[322+:2]}), 32'h0000_000e);
      check(32'({irq_enable_bank[182], irq_enable_bank[166:160]}), 32'h0000_00cf);
      check(32'(irq_req_r), 32'h0);
      cfg(3'h0, 8'h05, 32'h0000_0001);
      wait_cyc(3);
      expect_req(8'ha0, 8'ha0, 3'h3, 2'h1, 18'h2abcc);
      cfg(3'h0, 8'h05, 32'h0000_0006);
      wait_cyc(3);
      expect_req(8'ha1, 8'ha1, 3'h3, 2'h2, 18'h00100);
      cfg(3'h3, 8'h28, 32'h000e_0e10);
      wait_cyc(3);
      expect_req(8'ha0, 8'ha0, 3'h4, 2'h0, 18'h2abcc);
      @(posedge clk) multi_vec_en <= 1'b0;
      wait_cyc(3);
      expect_req(8'ha0, 8'h00, 3'h4, 2'h0, 18'h01234);
      @(posedge clk) multi_vec_en <= 1'b1;
      cfg(3'h1, 8'h05, 32'h0000_000f);
      wait_cyc(3);
      check(32'(irq_req_r), 32'h0);
      $display("test arbitrate done");
   endtask

   task automatic t_persist;
      @(posedge clk);
      src_evt[182] <= 1'b1;
      src_evt[166] <= 1'b1;
      wait_cyc(2);
      check(32'({irq_flag_bank[182], irq_flag_bank[166]}), 32'h3);
      cfg(3'h1, 8'h05, 32'h0040_0040);
      wait_cyc(2);
      check(32'({irq_flag_bank[182], irq_flag_bank[166]}), 32'h2);
      @(posedge clk) src_evt[182] <= 1'b0;
      cfg(3'h1, 8'h05, 32'h0040_0000);
      wait_cyc(2);
      check(32'(irq_flag_bank[182]), 32'h0);
      // Unused selector codes must leave every bank untouched
      cfg(3'h7, 8'h05, 32'h0000_0001);
      wait_cyc(2);
      check(32'({irq_flag_bank[160], irq_enable_bank[160]}), 32'h1);
      $display("test persist done");
   endtask

   task automatic t_ext;
      @(posedge clk) ext_pin[0] <= 1'b1;
      wait_cyc(6);
      check(32'(irq_flag_bank[3]), 32'h1);
      @(posedge clk) ext_pin[1] <= 1'b1;
      wait_cyc(6);
      check(32'(irq_flag_bank[8]), 32'h0);
      @(posedge clk) ext_pin[1] <= 1'b0;
      wait_cyc(6);
      check(32'(irq_flag_bank[8]), 32'h1);
      $display("test ext done");
   endtask

   initial begin
      {rst_b, cfg_we, cfg_sel, cfg_idx, cfg_wdata, src_evt, ext_pin} = '0;
      {error_cnt, tests_run} = '0;
      multi_vec_en = 1'b1;
      ext_rise_sel = 5'h01;
      srs_map = {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      wait_cyc(1);
      check(32'(irq_req_r | (|irq_flag_bank) | (|irq_enable_bank)), 32'h0);
      t_arbitrate();
      t_persist();
      t_ext();
      complete_run();
   end
endmodule
